// ---- logic/eeprom_pkg.sv ----
// Shared constants, state encodings and check-bit functions of the serial EEPROM client
package eeprom_pkg;

  localparam int ADDR_W = 18;              // Byte address bits of the array
  localparam int DATA_W = 32;              // Data bits of one storage word
  localparam int CHK_W = 6;                // Check bits of one storage word
  localparam int CW_W = DATA_W + CHK_W;    // Whole protected storage word, 38 bits
  localparam int WIDX_W = ADDR_W - 2;      // Storage word index bits
  localparam int PAGE_W = ADDR_W - 8;      // Page row bits
  localparam int PAGE_BYTES = 256;         // Bytes in one page
  localparam int CLK_PERIOD_NS = 5;        // mclk_i period
  localparam int WRITE_CYCLE_US = 5000;    // Self-timed write length, plain default
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_US * 1000 / CLK_PERIOD_NS;
  localparam logic [3:0] DEV_TYPE = 4'ha;  // Device type field of the address byte
  localparam logic [3:0] SYNC_RST = 4'h3;  // Idle levels of {a2, wp, sda, scl}
  localparam logic [DATA_W-1:0] ERASED_DATA = 32'hffff_ffff;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TX_ACK = 3'b100,
    ST_IGNORE = 3'b101,
    ST_TX_LOAD = 3'b110
  } link_st_e;

  typedef enum logic [1:0] {
    ROLE_DEV = 2'b00,
    ROLE_HI = 2'b01,
    ROLE_LO = 2'b10,
    ROLE_DATA = 2'b11
  } byte_role_e;

  typedef enum logic [1:0] {
    WC_IDLE = 2'b00,
    WC_READ = 2'b01,
    WC_MERGE = 2'b10,
    WC_WAIT = 2'b11
  } wcycle_e;

  // Hamming code over positions 1..38; check bits sit at the power-of-two positions
  function automatic logic [CW_W-1:0] ecc_encode(input logic [DATA_W-1:0] d);
    logic [CW_W:0] cw;
    logic [5:0] p;
    int j;
    cw = '0;
    p = '0;
    j = 0;
    for (int i = 1; i <= CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        cw[i] = d[j];
        j++;
      end
    end
    for (int i = 1; i <= CW_W; i++) begin
      if (cw[i]) begin
        p = p ^ i[5:0];
      end
    end
    for (int k = 0; k < CHK_W; k++) begin
      cw[1 << k] = p[k];
    end
    return cw[CW_W:1];
  endfunction

  // Syndrome names the failing position; a single bad bit is flipped back
  function automatic logic [DATA_W-1:0] ecc_decode(input logic [CW_W-1:0] c);
    logic [CW_W:0] cw;
    logic [5:0] s;
    logic [DATA_W-1:0] d;
    int j;
    cw = {c, 1'b0};
    s = '0;
    d = '0;
    j = 0;
    for (int i = 1; i <= CW_W; i++) begin
      if (cw[i]) begin
        s = s ^ i[5:0];
      end
    end
    if (s != 6'h00 && s <= 6'd38) begin
      cw[s] = ~cw[s];
    end
    for (int i = 1; i <= CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[j] = cw[i];
        j++;
      end
    end
    return d;
  endfunction

  localparam logic [CW_W-1:0] ERASED_CW = ecc_encode(ERASED_DATA);

endpackage

// ---- logic/pin_sync.sv ----
// Two-flop synchroniser for pin levels entering the mclk domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,           // Sampling clock
  input wire logic arst_n_i,        // Asynchronous reset, active low
  input wire logic [W-1:0] pin_i,   // Raw pin levels
  output logic [W-1:0] sync_o       // Synchronised levels
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta <= pin_i;
      sync_o <= meta;
    end
  end

endmodule

// ---- logic/word_store.sv ----
// Protected storage word array with registered read and one write port
`timescale 1ns/100ps
module word_store #(
  parameter int AW = eeprom_pkg::WIDX_W,
  parameter int DW = eeprom_pkg::CW_W
) (
  input wire logic clk_i,           // Clock
  input wire logic [AW-1:0] raddr_i,  // Read word index
  output logic [DW-1:0] rdata_o,    // Word read, one cycle after address
  input wire logic we_i,            // Write strobe
  input wire logic [AW-1:0] waddr_i,  // Write word index
  input wire logic [DW-1:0] wdata_i // Whole word with check bits
);

  logic [DW-1:0] mem [0:(1 << AW)-1];

  // Delivered state: every byte erased to ones, with matching check bits
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = eeprom_pkg::ERASED_CW;
    end
  end

  // No reset on the array; contents persist like nonvolatile cells
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// ---- logic/eeprom_client.sv ----
// Two-wire client of the serial EEPROM: protocol, page buffer and write cycle
`timescale 1ns/100ps
module eeprom_client #(
  parameter int WRITE_CYCLE_CYCLES = eeprom_pkg::WRITE_CYCLE_CYCLES
) (
  input wire logic mclk_i,          // System clock, 200 MHz
  input wire logic arst_n_i,        // Asynchronous reset, active low
  input wire logic scl_i,           // Bus clock pin level
  input wire logic sda_i,           // Bus data pin level
  output logic sda_o,               // Data drive level, always low
  output logic sda_oe_o,            // High while pulling data low
  input wire logic wp_i,            // Write-protect pin
  input wire logic a2_i,            // Client address strap pin
  output logic write_busy_o         // Self-timed write cycle running
);

  typedef struct packed {
    eeprom_pkg::link_st_e st;
    eeprom_pkg::byte_role_e role;
    eeprom_pkg::wcycle_e wc;
    logic scl_d;
    logic sda_d;
    logic [3:0] cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic ack;
    logic to_tx;
    logic is_write;
    logic [1:0] hi_top;
    logic [7:0] hi_byte;
    logic [eeprom_pkg::ADDR_W-1:0] cur_addr;
    logic [eeprom_pkg::PAGE_BYTES-1:0] mask;
    logic have_data;
    logic busy;
    logic [5:0] widx;
    logic [31:0] wc_cnt;
    logic [eeprom_pkg::PAGE_W-1:0] wc_page;
    logic sda_oe;
  } client_s;

  client_s q;
  client_s next_q;

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic a2_s;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic [7:0] byte_rx;
  logic [7:0] rd_byte;
  logic [eeprom_pkg::DATA_W-1:0] rd_word;
  logic [eeprom_pkg::DATA_W-1:0] merged;
  logic [eeprom_pkg::WIDX_W-1:0] mem_raddr;
  logic [eeprom_pkg::CW_W-1:0] mem_q;
  logic mem_we;
  logic [eeprom_pkg::CW_W-1:0] mem_wdata;
  logic pb_we;
  logic [7:0] pb_idx;
  logic [7:0] pb_data;
  logic word_touched;
  logic write_pending;
  logic [7:0] pbuf [0:eeprom_pkg::PAGE_BYTES-1];

  localparam logic [31:0] WC_LAST = 32'(WRITE_CYCLE_CYCLES - 1);

  // All four pins are outside the mclk domain
  pin_sync #(
    .W(4),
    .RST_VAL(eeprom_pkg::SYNC_RST)
  ) u_sync (
    .clk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .pin_i({a2_i, wp_i, sda_i, scl_i}),
    .sync_o({a2_s, wp_s, sda_s, scl_s})
  );

  // Write cycle owns the read port; otherwise it tracks the address counter
  assign mem_raddr = q.busy ? {q.wc_page, q.widx} : q.cur_addr[eeprom_pkg::ADDR_W-1:2];

  word_store u_store (
    .clk_i(mclk_i),
    .raddr_i(mem_raddr),
    .rdata_o(mem_q),
    .we_i(mem_we),
    .waddr_i({q.wc_page, q.widx}),
    .wdata_i(mem_wdata)
  );

  // Bus events from the synchronised levels
  assign rise = scl_s && !q.scl_d;
  assign fall = !scl_s && q.scl_d;
  assign start_det = scl_s && q.scl_d && q.sda_d && !sda_s;
  assign stop_det = scl_s && q.scl_d && !q.sda_d && sda_s;
  assign byte_rx = {q.rx_sh[6:0], sda_s};
  assign write_pending = q.is_write && q.have_data && !q.busy;

  // Read data is corrected before a byte is picked; the counter is stable long before use
  assign rd_word = eeprom_pkg::ecc_decode(mem_q);
  assign rd_byte = rd_word[{q.cur_addr[1:0], 3'b000} +: 8];

  // Unsent bytes keep their corrected old value
  always_comb begin
    merged = rd_word;
    word_touched = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (q.mask[{q.widx, 2'(b)}]) begin
        merged[8*b +: 8] = pbuf[{q.widx, 2'(b)}];
        word_touched = 1'b1;
      end
    end
  end

  // Protocol and write-cycle next state
  always_comb begin
    next_q = q;
    next_q.scl_d = scl_s;
    next_q.sda_d = sda_s;
    pb_we = 1'b0;
    pb_idx = q.cur_addr[7:0];
    pb_data = byte_rx;
    mem_we = 1'b0;
    mem_wdata = eeprom_pkg::ecc_encode(merged);

    if (stop_det) begin
      // Protect level is taken here once; the running cycle never looks again
      if (write_pending && q.role == eeprom_pkg::ROLE_DATA) begin
        if (!wp_s) begin
          next_q.busy = 1'b1;
          next_q.wc = eeprom_pkg::WC_READ;
          next_q.widx = '0;
          next_q.wc_cnt = '0;
          next_q.wc_page = q.cur_addr[eeprom_pkg::ADDR_W-1:8];
        end else begin
          next_q.mask = '0;
        end
      end
      next_q.have_data = 1'b0;
      next_q.st = eeprom_pkg::ST_IDLE;
      next_q.sda_oe = 1'b0;
    end else if (start_det) begin
      // A restart without Stop drops any staged bytes unless a write cycle is running
      if (!q.busy) begin
        next_q.mask = '0;
        next_q.have_data = 1'b0;
      end
      next_q.st = eeprom_pkg::ST_RX;
      next_q.role = eeprom_pkg::ROLE_DEV;
      next_q.cnt = '0;
      next_q.to_tx = 1'b0;
      next_q.sda_oe = 1'b0;
    end else begin
      case (q.st)
        eeprom_pkg::ST_RX: begin
          if (rise && q.cnt < 4'd8) begin
            next_q.rx_sh = byte_rx;
            next_q.cnt = q.cnt + 4'd1;
            if (q.cnt == 4'd7) begin
              next_q.ack = 1'b1;
              next_q.to_tx = 1'b0;
              case (q.role)
                eeprom_pkg::ROLE_DEV: begin
                  // Busy means no answer, which is what a polling host waits on
                  if (byte_rx[7:4] == eeprom_pkg::DEV_TYPE && byte_rx[3] == a2_s
                      && !q.busy) begin
                    next_q.is_write = !byte_rx[0];
                    next_q.to_tx = byte_rx[0];
                    next_q.hi_top = byte_rx[2:1];
                    next_q.role = byte_rx[0] ? eeprom_pkg::ROLE_DATA : eeprom_pkg::ROLE_HI;
                  end else begin
                    next_q.ack = 1'b0;
                  end
                end
                eeprom_pkg::ROLE_HI: begin
                  next_q.hi_byte = byte_rx;
                  next_q.role = eeprom_pkg::ROLE_LO;
                end
                eeprom_pkg::ROLE_LO: begin
                  // Dummy write ends here when the host restarts for a read
                  next_q.cur_addr = {q.hi_top, q.hi_byte, byte_rx};
                  next_q.role = eeprom_pkg::ROLE_DATA;
                end
                default: begin
                  // Staged data; low byte wraps inside the page
                  pb_we = 1'b1;
                  next_q.mask[q.cur_addr[7:0]] = 1'b1;
                  next_q.have_data = 1'b1;
                  next_q.cur_addr[7:0] = q.cur_addr[7:0] + 8'h01;
                end
              endcase
            end
          end else if (fall && q.cnt == 4'd8) begin
            next_q.sda_oe = q.ack;
            next_q.st = q.ack ? eeprom_pkg::ST_RX_ACK : eeprom_pkg::ST_IGNORE;
          end
        end
        eeprom_pkg::ST_RX_ACK: begin
          if (fall) begin
            next_q.cnt = '0;
            next_q.sda_oe = 1'b0;
            next_q.st = eeprom_pkg::ST_RX;
            if (q.to_tx) begin
              next_q.tx_sh = rd_byte;
              next_q.sda_oe = !rd_byte[7];
              next_q.cur_addr = q.cur_addr + 18'h0_0001;
              next_q.st = eeprom_pkg::ST_TX;
            end
          end
        end
        eeprom_pkg::ST_TX: begin
          if (fall) begin
            if (q.cnt == 4'd7) begin
              next_q.sda_oe = 1'b0;
              next_q.st = eeprom_pkg::ST_TX_ACK;
            end else begin
              next_q.cnt = q.cnt + 4'd1;
              next_q.tx_sh = {q.tx_sh[6:0], 1'b0};
              next_q.sda_oe = !q.tx_sh[6];
            end
          end
        end
        eeprom_pkg::ST_TX_ACK: begin
          // High on the ninth clock ends the read; low asks for more
          if (rise) begin
            next_q.st = sda_s ? eeprom_pkg::ST_IGNORE : eeprom_pkg::ST_TX_LOAD;
          end
        end
        eeprom_pkg::ST_TX_LOAD: begin
          if (fall) begin
            next_q.cnt = '0;
            next_q.tx_sh = rd_byte;
            next_q.sda_oe = !rd_byte[7];
            next_q.cur_addr = q.cur_addr + 18'h0_0001;
            next_q.st = eeprom_pkg::ST_TX;
          end
        end
        eeprom_pkg::ST_IGNORE: begin
          next_q.sda_oe = 1'b0;
        end
        default: begin
          next_q.sda_oe = 1'b0;
        end
      endcase
    end

    // Self-timed write: read, merge and rewrite each touched word of the page
    if (q.busy) begin
      next_q.wc_cnt = q.wc_cnt + 32'h0000_0001;
      case (q.wc)
        eeprom_pkg::WC_READ: begin
          next_q.wc = eeprom_pkg::WC_MERGE;
        end
        eeprom_pkg::WC_MERGE: begin
          mem_we = word_touched;
          next_q.widx = q.widx + 6'h01;
          next_q.wc = (q.widx == 6'h3f) ? eeprom_pkg::WC_WAIT : eeprom_pkg::WC_READ;
        end
        eeprom_pkg::WC_WAIT: begin
          if (q.wc_cnt >= WC_LAST) begin
            next_q.busy = 1'b0;
            next_q.wc = eeprom_pkg::WC_IDLE;
            next_q.mask = '0;
          end
        end
        default: begin
          next_q.wc = eeprom_pkg::WC_IDLE;
        end
      endcase
    end
  end

  // Page staging bytes; no reset needed since the mask says which are live
  always_ff @(posedge mclk_i) begin
    if (pb_we) begin
      pbuf[pb_idx] <= pb_data;
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.scl_d <= 1'b1;
      q.sda_d <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign sda_o = 1'b0 & q.sda_oe;
  assign sda_oe_o = q.sda_oe;
  assign write_busy_o = q.busy;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_dev_byte_done;
    q.st == eeprom_pkg::ST_RX && rise && q.cnt == 4'd7 && q.role == eeprom_pkg::ROLE_DEV;
  endsequence

  sequence s_write_stop;
    stop_det && write_pending && q.role == eeprom_pkg::ROLE_DATA;
  endsequence

  a_busy_no_ack: assert property (s_dev_byte_done and q.busy |=> !q.ack)
    else $error("address acked during write cycle");

  a_stop_starts: assert property (s_write_stop and !wp_s
    |=> q.busy && q.wc == eeprom_pkg::WC_READ)
    else $error("write cycle did not start at stop");

  a_protect_blocks: assert property (s_write_stop and wp_s |=> !q.busy ##1 !q.busy)
    else $error("write cycle started while protected");

  a_cycle_holds: assert property (q.busy && q.wc_cnt < WC_LAST |=> q.busy)
    else $error("write cycle ended early");

  a_cycle_length: assert property ($fell(q.busy) |-> $past(q.wc_cnt) == WC_LAST)
    else $error("write cycle length wrong");

  a_read_wrap: assert property (q.st == eeprom_pkg::ST_TX_LOAD && fall && (&q.cur_addr)
    |=> q.cur_addr == '0)
    else $error("address counter did not wrap");

  a_nack_ends: assert property (q.st == eeprom_pkg::ST_TX_ACK && rise && sda_s
    |=> q.st == eeprom_pkg::ST_IGNORE ##1 !q.sda_oe)
    else $error("read went on after host no-ack");

  a_tx_first_bit: assert property (q.st == eeprom_pkg::ST_RX_ACK && fall && q.to_tx
    |=> q.st == eeprom_pkg::ST_TX && q.sda_oe == !q.tx_sh[7]
    && q.cur_addr == $past(q.cur_addr) + 18'h0_0001)
    else $error("read byte not started from counter");

  a_no_write_idle: assert property (!q.busy |-> !mem_we)
    else $error("array written outside write cycle");

endmodule

// ---- verif/bus_host_model.sv ----
// Two-wire bus host model: makes the bus clock and pulls the data line low
`timescale 1ns/100ps
module bus_host_model (
  input wire logic clk_i,   // Pacing clock
  input wire logic sda_i,   // Resolved data line
  output logic scl_o,       // Bus clock, stands high outside frames
  output logic sda_low_o    // High while pulling data low
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // One quarter of the 80 ns bus clock period
  task automatic q();
    repeat (4) @(negedge clk_i);
  endtask

  // Serves from an idle bus and as a repeated start with the clock low
  task automatic start();
    sda_low_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b0;
    q();
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b0;
    q();
  endtask

  // Data moves only while the clock is low; sampled mid high phase
  task automatic bit_io(input logic b, output logic got);
    sda_low_o = ~b;
    q();
    scl_o = 1'b1;
    q();
    got = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask

  // Sends MSB first and returns the client's acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], g);
    end
    bit_io(1'b1, g);
    ack = ~g;
  endtask

  // Releasing the line on the ninth clock ends the read
  task automatic rbyte(input logic more, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~more, g);
  endtask
endmodule

// ---- verif/test_eeprom_client.sv ----
// Self-checking bench of the serial EEPROM client
`timescale 1ns/100ps
module test_eeprom_client;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wp_i = 1'b0;
  logic a2_i = 1'b1;
  logic scl;
  logic sda_low;
  logic sda;
  logic sda_o;
  logic sda_oe_o;
  logic write_busy_o;
  int err_total = 0;
  int total_checks = 0;

  always #2.5 mclk_i = ~mclk_i;

  // Pulled-up data line: low while any party pulls it
  assign sda = ~(sda_low | (sda_oe_o & ~sda_o));

  // Short write cycle keeps polling brief
  eeprom_client #(.WRITE_CYCLE_CYCLES(200)) dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .wp_i(wp_i), .a2_i(a2_i), .write_busy_o(write_busy_o));

  bus_host_model host (.clk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Top array bits ride in bits 2:1, strap bit 3 set
  function automatic logic [7:0] dev_byte(input logic [17:0] a, input logic rw);
    return {eeprom_pkg::DEV_TYPE, 1'b1, a[17:16], rw};
  endfunction

  // Dummy write loading the counter, no data and no stop
  task automatic point(input logic [17:0] a);
    logic k;
    host.start();
    host.wbyte(dev_byte(a, 1'b0), k);
    chk(k, 8'h01, "address ack");
    host.wbyte(a[15:8], k);
    chk(k, 8'h01, "high ack");
    host.wbyte(a[7:0], k);
    chk(k, 8'h01, "low ack");
  endtask

  // Reads n bytes from the counter, acking all but the last
  task automatic rd(input int n, input logic [31:0] exp);
    logic k;
    logic [7:0] b;
    host.start();
    host.wbyte(dev_byte(18'h0_0000, 1'b1), k);
    chk(k, 8'h01, "read address ack");
    for (int i = 0; i < n; i++) begin
      host.rbyte(i < n - 1, b);
      chk(b, exp[31-8*i-:8], "read data");
    end
    chk(sda, 8'h01, "line free after nack");
    host.stop();
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic k;
    point(a);
    host.wbyte(d, k);
    chk(k, 8'h01, "data ack");
    host.stop();
  endtask

  // Bounded polling until the address byte is acknowledged
  task automatic poll();
    logic k;
    int tries;
    tries = 0;
    k = 1'b0;
    while (!k && tries < 40) begin
      host.start();
      host.wbyte(dev_byte(18'h0_0000, 1'b0), k);
      host.stop();
      tries++;
    end
    chk(k, 8'h01, "poll ack");
    chk(write_busy_o, 8'h00, "cycle over");
  endtask

  task automatic t_erased();
    logic k;
    host.start();
    host.wbyte({eeprom_pkg::DEV_TYPE, 4'h0}, k);
    host.stop();
    chk(k, 8'h00, "other strap refused");
    rd(2, 32'hffff_0000);
  endtask

  task automatic t_write_poll();
    logic k;
    wr(18'h2_1235, 8'h5a);
    repeat (2) @(negedge mclk_i);
    chk(write_busy_o, 8'h01, "busy after stop");
    host.start();
    host.wbyte(dev_byte(18'h0_0000, 1'b1), k);
    host.stop();
    chk(k, 8'h00, "read refused while busy");
    poll();
    rd(1, 32'hff00_0000);
    point(18'h2_1234);
    // Next byte is 5a, so a missed no-ack would pull the line low
    rd(1, 32'hff00_0000);
    rd(3, 32'h5aff_ff00);
  endtask

  task automatic t_wrap();
    wr(18'h0_0000, 8'h3c);
    poll();
    // Top address is reached by a host-acked load, not the first one
    point(18'h3_fffe);
    rd(3, 32'hffff_3c00);
    rd(1, 32'hff00_0000);
  endtask

  task automatic t_protect();
    logic k;
    wp_i = 1'b1;
    wr(18'h0_0010, 8'h11);
    repeat (8) @(negedge mclk_i);
    chk(write_busy_o, 8'h00, "no cycle when protected");
    host.start();
    host.wbyte(dev_byte(18'h0_0000, 1'b0), k);
    host.stop();
    chk(k, 8'h01, "ready at once");
    wp_i = 1'b0;
    point(18'h0_0010);
    rd(1, 32'hff00_0000);
    wr(18'h0_0010, 8'h22);
    // Protect raised after the stop must leave the started cycle alone
    wp_i = 1'b1;
    poll();
    wp_i = 1'b0;
    point(18'h0_0010);
    rd(1, 32'h2200_0000);
  endtask

  // Three bytes from 1fe: the third wraps to the page start at 100
  task automatic t_page();
    logic k;
    point(18'h0_01fe);
    for (int i = 0; i < 3; i++) begin
      host.wbyte(8'h81 + 8'(i), k);
      chk(k, 8'h01, "page data ack");
    end
    host.stop();
    poll();
    rd(1, 32'hff00_0000);
    point(18'h0_01fe);
    rd(3, 32'h8182_ff00);
    point(18'h0_0100);
    rd(2, 32'h83ff_0000);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge mclk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    t_erased();
    t_write_poll();
    t_wrap();
    t_protect();
    t_page();
    report_and_stop();
  end

  // About three times the expected run, cuts a hung handshake short
  initial begin
    #200_000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
